// file: design/runaway_code_watchdog.sv
/*
  Runaway code watchdog: 12-bit prescaler and 6-bit counter on the oscillator
  clock, Avalon-MM register slave, reset pulse generator.
  Assumes clk is the oscillator output, reset_n is the power-on reset, and
  all CPU-side event inputs are synchronous to clk.
*/
`default_nettype none
module runaway_code_watchdog (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic [wdog_pkg::ADDR_W-1:0] address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [31:0]                 writedata,
  output logic      [31:0]                 readdata,
  output logic                             waitrequest,
  input  wire logic [7:0]                  reset_vector_lo,
  input  wire logic [15:0]                 cpu_addr,
  input  wire logic                        cpu_addr_valid,
  input  wire logic                        stop_exec,
  input  wire logic                        stop_mode,
  input  wire logic                        internal_reset,
  input  wire logic                        monitor_mode,
  input  wire logic                        vectors_blank,
  input  wire logic                        irq_test_level,
  input  wire logic                        rst_test_level,
  input  wire logic                        break_active,
  output logic                             rst_pin_out,
  output logic                             rst_pin_oe,
  output logic                             illegal_op_reset,
  output logic                             watchdog_disable,
  output logic                             watchdog_rate_sel
);
  function automatic logic is_vector_addr(input logic [15:0] a);
    is_vector_addr = (a == wdog_pkg::VEC_HI_ADDR) || (a == wdog_pkg::VEC_LO_ADDR);
  endfunction

  // Bus group
  logic        waitrequest_q, waitrequest_d;
  logic [31:0] readdata_q, readdata_d;
  logic        cfg_locked_q, cfg_locked_d;
  wdog_pkg::cfg_t cfg_q, cfg_d;

  // Watchdog group
  logic [wdog_pkg::TOTAL_W-1:0] cnt_q, cnt_d;
  logic [12:0]                  por_cnt_q, por_cnt_d;
  logic                         flag_q, flag_d;
  logic                         mon_prev_q, mon_prev_d;
  logic                         mon_test_q, mon_test_d;
  logic                         mon_blank_q, mon_blank_d;
  logic [4:0]                   pulse_cnt_q, pulse_cnt_d;
  wdog_pkg::pulse_state_t       state_q, state_d;
  logic                         oe_q, oe_d;
  logic                         illegal_q, illegal_d;
  logic                         dis_out_q, dis_out_d;
  logic                         rate_out_q, rate_out_d;

  logic [15:0] idx;
  logic        acc_wr;
  logic        svc_wr;
  logic        status_wr;
  logic        disabled;
  logic        running;
  logic        timeout;
  logic [wdog_pkg::TOTAL_W-1:0] limit;

  assign idx       = address[wdog_pkg::ADDR_W-1:2];
  assign acc_wr    = write && !waitrequest_q;
  assign svc_wr    = acc_wr && (idx == wdog_pkg::SERVICE_IDX);
  assign status_wr = acc_wr && (idx == wdog_pkg::STATUS_IDX);

  // Disable sources: configuration, monitor entries, break
  assign disabled = cfg_q.disable_bit
                  || (mon_test_q && (irq_test_level || rst_test_level))
                  || mon_blank_q
                  || (break_active && rst_test_level);
  // Wait mode is not a gating term, so counting carries on through it
  assign running  = !disabled && !stop_mode;
  assign limit    = cfg_q.rate_sel ? wdog_pkg::LIMIT_FAST : wdog_pkg::LIMIT_SLOW;
  assign timeout  = running && (state_q == wdog_pkg::PS_IDLE)
                  && (cnt_q == limit - 18'h00001);

  // Bus slave: one wait cycle, answer registered
  always_comb begin
    waitrequest_d = !((read || write) && waitrequest_q);
    readdata_d    = readdata_q;
    cfg_d         = cfg_q;
    cfg_locked_d  = cfg_locked_q;
    if (read && waitrequest_q) begin
      readdata_d = 32'h0000_0000;
      if (idx == wdog_pkg::SERVICE_IDX) begin
        readdata_d[7:0] = reset_vector_lo;
      end else if (idx == wdog_pkg::STATUS_IDX) begin
        readdata_d[wdog_pkg::ST_FLAG_BIT]  = flag_q;
        readdata_d[wdog_pkg::ST_DIS_BIT]   = disabled;
        readdata_d[wdog_pkg::ST_PULSE_BIT] = oe_q;
        readdata_d[wdog_pkg::ST_CNT_LSB +: wdog_pkg::CNT_W] =
          cnt_q[wdog_pkg::PRESC_W +: wdog_pkg::CNT_W];
        readdata_d[wdog_pkg::ST_PRE_LSB +: wdog_pkg::PRESC_W] = cnt_q[wdog_pkg::PRESC_W-1:0];
      end else if (idx == wdog_pkg::CONFIG_IDX) begin
        readdata_d[wdog_pkg::CF_DIS_BIT]  = cfg_q.disable_bit;
        readdata_d[wdog_pkg::CF_RATE_BIT] = cfg_q.rate_sel;
        readdata_d[wdog_pkg::CF_STOP_BIT] = cfg_q.stop_en;
      end
    end
    // Configuration latch takes one write per reset, like the real option bits
    if (acc_wr && (idx == wdog_pkg::CONFIG_IDX) && !cfg_locked_q) begin
      cfg_d.disable_bit = writedata[wdog_pkg::CF_DIS_BIT];
      cfg_d.rate_sel    = writedata[wdog_pkg::CF_RATE_BIT];
      cfg_d.stop_en     = writedata[wdog_pkg::CF_STOP_BIT];
      cfg_locked_d      = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || internal_reset || oe_q) begin
      waitrequest_q <= 1'b1;
      readdata_q    <= 32'h0000_0000;
      cfg_q         <= wdog_pkg::CFG_RESET;
      cfg_locked_q  <= 1'b0;
    end else begin
      waitrequest_q <= waitrequest_d;
      readdata_q    <= readdata_d;
      cfg_q         <= cfg_d;
      cfg_locked_q  <= cfg_locked_d;
    end
  end

  // Watchdog counting, monitor latches and reset pulse
  always_comb begin
    cnt_d       = cnt_q;
    por_cnt_d   = por_cnt_q;
    flag_d      = flag_q;
    mon_prev_d  = monitor_mode;
    mon_test_d  = mon_test_q;
    mon_blank_d = mon_blank_q;
    pulse_cnt_d = pulse_cnt_q;
    state_d     = state_q;
    illegal_d   = stop_exec && !cfg_q.stop_en;
    dis_out_d   = cfg_q.disable_bit;
    rate_out_d  = cfg_q.rate_sel;

    if (monitor_mode && !mon_prev_q) begin
      if (irq_test_level) begin
        mon_test_d = 1'b1;
      end else if (vectors_blank) begin
        mon_blank_d = 1'b1;
      end
    end
    if (!monitor_mode) begin
      mon_test_d = 1'b0;
    end

    if (running) begin
      cnt_d = cnt_q + 18'h00001;
    end
    if (stop_mode || (stop_exec && cfg_q.stop_en)) begin
      cnt_d[wdog_pkg::PRESC_W-1:0] = '0;
    end
    if (cpu_addr_valid && is_vector_addr(cpu_addr)) begin
      cnt_d[wdog_pkg::PRESC_W-1:0] = '0;
    end
    if (por_cnt_q != wdog_pkg::POR_CLR_COUNT) begin
      por_cnt_d = por_cnt_q + 13'h0001;
      if (por_cnt_d == wdog_pkg::POR_CLR_COUNT) begin
        cnt_d[wdog_pkg::PRESC_W-1:0] = '0;
      end
    end
    if (svc_wr) begin
      cnt_d[wdog_pkg::TOTAL_W-1:wdog_pkg::SVC_KEEP_W] = '0;
    end

    if (status_wr && writedata[wdog_pkg::ST_FLAG_BIT]) begin
      flag_d = 1'b0;
    end

    // No interrupt output exists: a timeout starts the reset pulse and sets the status flag
    case (state_q)
      wdog_pkg::PS_IDLE: begin
        if (timeout) begin
          state_d     = wdog_pkg::PS_PULSE;
          pulse_cnt_d = 5'h00;
          flag_d      = 1'b1;
        end
      end
      wdog_pkg::PS_PULSE: begin
        pulse_cnt_d = pulse_cnt_q + 5'h01;
        if (pulse_cnt_q == wdog_pkg::PULSE_LAST) begin
          state_d = wdog_pkg::PS_IDLE;
        end
      end
      default: state_d = wdog_pkg::PS_IDLE;
    endcase
    oe_d = (state_d == wdog_pkg::PS_PULSE);

    if (internal_reset || state_q == wdog_pkg::PS_PULSE) begin
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q       <= '0;
      por_cnt_q   <= 13'h0000;
      flag_q      <= 1'b0;
      mon_prev_q  <= 1'b0;
      mon_test_q  <= 1'b0;
      mon_blank_q <= 1'b0;
      pulse_cnt_q <= 5'h00;
      state_q     <= wdog_pkg::PS_IDLE;
      oe_q        <= 1'b0;
      illegal_q   <= 1'b0;
      dis_out_q   <= 1'b0;
      rate_out_q  <= 1'b0;
    end else begin
      cnt_q       <= cnt_d;
      por_cnt_q   <= por_cnt_d;
      flag_q      <= flag_d;
      mon_prev_q  <= mon_prev_d;
      mon_test_q  <= mon_test_d;
      mon_blank_q <= mon_blank_d;
      pulse_cnt_q <= pulse_cnt_d;
      state_q     <= state_d;
      oe_q        <= oe_d;
      illegal_q   <= illegal_d;
      dis_out_q   <= dis_out_d;
      rate_out_q  <= rate_out_d;
    end
  end

  // Pin level is always low; only the enable moves, as on an open-drain pad
  logic rst_out_q;
  always_ff @(posedge clk) begin
    rst_out_q <= 1'b0;
  end

  assign readdata          = readdata_q;
  assign waitrequest       = waitrequest_q;
  assign rst_pin_out       = rst_out_q;
  assign rst_pin_oe        = oe_q;
  assign illegal_op_reset  = illegal_q;
  assign watchdog_disable  = dis_out_q;
  assign watchdog_rate_sel = rate_out_q;
endmodule
`default_nettype wire

// file: design/wdog_pkg.sv
/*
  Shared constants and types of the runaway code watchdog: register map,
  field positions, timeout limits and pulse lengths.
  Assumes a 32-bit Avalon-MM bus with byte addresses and one word per register.
*/
`default_nettype none
package wdog_pkg;
  localparam int unsigned ADDR_W       = 18;
  localparam int unsigned PRESC_W      = 12;
  localparam int unsigned CNT_W        = 6;
  localparam int unsigned TOTAL_W      = PRESC_W + CNT_W;
  localparam int unsigned SVC_KEEP_W   = 4;

  // Register indices; byte address is four times the index
  localparam logic [15:0] SERVICE_IDX  = 16'hffff;
  localparam logic [15:0] STATUS_IDX   = 16'h0010;
  localparam logic [15:0] CONFIG_IDX   = 16'h001e;

  // Status fields
  localparam int unsigned ST_FLAG_BIT  = 0;
  localparam int unsigned ST_DIS_BIT   = 1;
  localparam int unsigned ST_PULSE_BIT = 2;
  localparam int unsigned ST_CNT_LSB   = 8;
  localparam int unsigned ST_PRE_LSB   = 16;

  // Config fields
  localparam int unsigned CF_DIS_BIT   = 0;
  localparam int unsigned CF_RATE_BIT  = 1;
  localparam int unsigned CF_STOP_BIT  = 2;

  // Timeout limits in oscillator cycles: 2^18-2^4 and 2^13-2^4
  localparam logic [TOTAL_W-1:0] LIMIT_SLOW = 18'h3fff0;
  localparam logic [TOTAL_W-1:0] LIMIT_FAST = 18'h01ff0;

  localparam logic [4:0]  PULSE_LAST    = 5'h1f;   // 32 cycles low
  localparam logic [12:0] POR_CLR_COUNT = 13'h1000; // 4096 cycles

  localparam logic [15:0] VEC_HI_ADDR  = 16'hfffe;
  localparam logic [15:0] VEC_LO_ADDR  = 16'hffff;

  typedef struct packed {
    logic stop_en;
    logic rate_sel;
    logic disable_bit;
  } cfg_t;

  localparam cfg_t CFG_RESET = 3'h0;

  typedef enum logic [1:0] {
    PS_IDLE  = 2'b01,
    PS_PULSE = 2'b10
  } pulse_state_t;
endpackage
`default_nettype wire

// file: bench/wdog_asserts.sv
/* Port checker for the runaway code watchdog.
   Bound to every runaway_code_watchdog instance; sees its ports only. */
`default_nettype none
module wdog_asserts (
  input wire logic                        clk,
  input wire logic                        reset_n,
  input wire logic [wdog_pkg::ADDR_W-1:0] address,
  input wire logic                        read,
  input wire logic [31:0]                 readdata,
  input wire logic                        waitrequest,
  input wire logic [7:0]                  reset_vector_lo,
  input wire logic                        stop_exec,
  input wire logic                        stop_mode,
  input wire logic                        rst_pin_out,
  input wire logic                        rst_pin_oe,
  input wire logic                        illegal_op_reset,
  input wire logic                        watchdog_disable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] oe_cnt_q;
  logic [5:0] oe_cnt_d;
  always_comb oe_cnt_d = rst_pin_oe ? oe_cnt_q + 6'h01 : 6'h00;
  always_ff @(posedge clk) oe_cnt_q <= reset_n ? oe_cnt_d : 6'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence svc_read_ans;
    read && !waitrequest && address[17:2] == wdog_pkg::SERVICE_IDX;
  endsequence
  sequence pulse_end;
    $fell(rst_pin_oe);
  endsequence
  a_svc_read: assert property (svc_read_ans |-> readdata[7:0] == $past(reset_vector_lo))
    else $error("service read lost vector byte");
  a_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  a_pulse_len: assert property (pulse_end |-> oe_cnt_q == 6'h20)
    else $error("reset pulse length wrong");
  a_pulse_max: assert property (oe_cnt_q <= 6'h20)
    else $error("reset pulse too long");
  a_pin_low: assert property (rst_pin_oe |-> !rst_pin_out)
    else $error("reset pin driven high");
  // Three cycles: the disable copy lags its latch
  a_stop_hold: assert property (stop_mode [*3] |-> !$rose(rst_pin_oe))
    else $error("timeout while clock gated");
  a_dis_hold: assert property (watchdog_disable [*3] |-> !$rose(rst_pin_oe))
    else $error("timeout while disabled");
  a_illegal_cause: assert property (illegal_op_reset |-> $past(stop_exec))
    else $error("illegal opcode reset without stop");
endmodule
bind runaway_code_watchdog wdog_asserts i_wdog_asserts (.clk(clk), .reset_n(reset_n), .address(address),
  .read(read), .readdata(readdata), .waitrequest(waitrequest), .reset_vector_lo(reset_vector_lo),
  .stop_exec(stop_exec), .stop_mode(stop_mode), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
  .illegal_op_reset(illegal_op_reset), .watchdog_disable(watchdog_disable));
`default_nettype wire

// file: bench/cpu_bus_model.sv
/* CPU bus model: random non-vector traffic, vector fetch on request.
   Assumes fetch is driven just after a rising edge. */
`default_nettype none
module cpu_bus_model (
  input  wire logic        clk,
  input  wire logic        fetch,
  output logic      [15:0] cpu_addr,
  output logic             cpu_addr_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk) begin
    cpu_addr_valid <= fetch | 1'($urandom_range(1));
    // Idle address keeps moving so a stale value never looks valid
    cpu_addr <= fetch ? wdog_pkg::VEC_HI_ADDR : 16'($urandom_range(16'hefff));
  end
endmodule
`default_nettype wire

// file: bench/runaway_code_watchdog_tb_top.sv
/* Self-checking bench of the runaway code watchdog.
   Assumes the checker is bound and the CPU model drives the bus address. */
`default_nettype none
module runaway_code_watchdog_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [17:0] address = 18'h00000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic        fetch = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic [7:0]  vec_lo = 8'h00;
  logic [7:0]  v;
  logic        stop_exec = 1'b0;
  logic        stop_mode = 1'b0;
  logic        int_rst = 1'b0;
  logic [4:0]  mode = 5'h00;
  logic        waitrequest, rst_pin_out, rst_pin_oe, illegal_op_reset, wd_dis, wd_rate, valid;
  logic [15:0] cpu_addr;
  int          bad_count = 0, cmp_count = 0, cyc = 0, n, oe_hits;
  always #10 clk = ~clk;
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic quiet(input int k);
    repeat (k) begin
      @(posedge clk);
      if (rst_pin_oe !== 1'b0) oe_hits++;
    end
  endtask
  task automatic ireset;
    int_rst <= 1'b1;
    @(posedge clk);
    int_rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic mode_chk(input logic [4:0] m, input logic e);
    mode <= m;
    quiet(3);
    bus(1'b0, wdog_pkg::STATUS_IDX, 32'h0);
    chk("disabled", rd[wdog_pkg::ST_DIS_BIT], e);
  endtask
  initial begin
    void'($urandom(32'hafb4));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    quiet(4200);
    v = 8'($urandom);
    vec_lo <= v;
    bus(1'b0, wdog_pkg::SERVICE_IDX, 32'h0);
    chk("service_read", rd[7:0], v);
    bus(1'b0, 16'h0123, 32'h0);
    chk("unmapped_read", rd, 32'h0);
    $display("decode test done");
    ireset();
    bus(1'b1, wdog_pkg::CONFIG_IDX, 32'h2);
    bus(1'b1, wdog_pkg::CONFIG_IDX, 32'h1);
    chk("rate_sel", wd_rate, 1'b1);
    chk("disable_once", wd_dis, 1'b0);
    n = 7;
    while (rst_pin_oe !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    chk("timeout_window", n >= 8170 && n <= 8185, 1'b1);
    n = 0;
    while (rst_pin_oe === 1'b1 && n < 99) begin
      @(posedge clk);
      n++;
    end
    chk("pulse_len", n, 32);
    chk("rate_cleared", wd_rate, 1'b0);
    bus(1'b0, wdog_pkg::STATUS_IDX, 32'h0);
    chk("flag", rd[wdog_pkg::ST_FLAG_BIT], 1'b1);
    $display("timeout test done");
    bus(1'b1, wdog_pkg::CONFIG_IDX, 32'h2);
    oe_hits = 0;
    repeat (3) begin
      fetch <= 1'b1;
      @(posedge clk);
      fetch <= 1'b0;
      // Fetch clears the prescaler two edges on; one more count before the snapshot
      quiet(2);
      bus(1'b0, wdog_pkg::STATUS_IDX, 32'h0);
      chk("fetch_clear", rd[wdog_pkg::ST_PRE_LSB +: wdog_pkg::PRESC_W], 32'h1);
      quiet(1000 + $urandom_range(5000));
      bus(1'b1, wdog_pkg::SERVICE_IDX, $urandom);
    end
    chk("served_quiet", oe_hits, 0);
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    @(posedge clk);
    chk("illegal_op", illegal_op_reset, 1'b1);
    bus(1'b1, wdog_pkg::SERVICE_IDX, 32'h0);
    stop_mode <= 1'b1;
    quiet(9000);
    stop_mode <= 1'b0;
    chk("stop_quiet", oe_hits, 0);
    ireset();
    bus(1'b1, wdog_pkg::CONFIG_IDX, 32'h3);
    quiet(9000);
    chk("disabled_quiet", oe_hits, 0);
    chk("disable_out", wd_dis, 1'b1);
    $display("service and hold tests done");
    ireset();
    mode_chk(5'h03, 1'b1);
    mode_chk(5'h00, 1'b0);
    mode_chk(5'h14, 1'b1);
    mode_chk(5'h10, 1'b0);
    mode_chk(5'h00, 1'b0);
    mode_chk(5'h18, 1'b1);
    mode_chk(5'h00, 1'b1);
    $display("mode test done");
    complete_run();
  end
  cpu_bus_model i_cpu_bus_model (.clk(clk), .fetch(fetch), .cpu_addr(cpu_addr), .cpu_addr_valid(valid));
  runaway_code_watchdog i_runaway_code_watchdog (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .reset_vector_lo(vec_lo), .cpu_addr(cpu_addr), .cpu_addr_valid(valid), .stop_exec(stop_exec),
    .stop_mode(stop_mode), .internal_reset(int_rst), .monitor_mode(mode[4]), .vectors_blank(mode[3]),
    .irq_test_level(mode[2]), .rst_test_level(mode[1]), .break_active(mode[0]), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe), .illegal_op_reset(illegal_op_reset), .watchdog_disable(wd_dis),
    .watchdog_rate_sel(wd_rate));
endmodule
`default_nettype wire
